// file: iolcb_bank.sv
// io line control bank: per-line config, change status and pad drive over apb
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module iolcb_bank #(
  parameter int unsigned LINES = iolcb_pkg::MAX_LINES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] pad_in,
  output logic [31:0] pad_out,
  output logic [31:0] pad_oe,
  output logic [31:0] pullup_en,
  output logic [31:0] periph_b_sel,
  output logic irq
);

  // elaboration check on line count
  if (LINES < 1 || LINES > iolcb_pkg::MAX_LINES) begin : g_bad_lines
    $error("LINES must be 1 to 32");
  end

  localparam logic [31:0] LINE_MASK = (LINES == 32) ? 32'hffff_ffff : ((32'h1 << LINES) - 32'h1);

  iolcb_pkg::iolcb_state_s st_q;
  iolcb_pkg::iolcb_state_s st_d;
  iolcb_pkg::iolcb_apb_req_s req;
  logic setup;
  logic wr_done;
  logic rd_done;
  logic [31:0] agree;
  logic [31:0] chg_set;
  logic [31:0] chg_clr;
  logic [31:0] rdata;
  logic mapped;

  // bundle the bus request
  assign req.sel = psel;
  assign req.enable = penable;
  assign req.write = pwrite;
  assign req.addr = paddr;
  assign req.wdata = pwdata & LINE_MASK;

  // transfer phases; the slave always finishes in the first access cycle
  assign setup = req.sel & ~req.enable;
  assign wr_done = req.sel & req.enable & st_q.pready & req.write;
  assign rd_done = req.sel & req.enable & st_q.pready & ~req.write;

  // read mux, evaluated in the setup cycle
  always_comb begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    case (req.addr)
      iolcb_pkg::OFS_OUT_EN: rdata = st_q.out_en;
      iolcb_pkg::OFS_OUT_DATA: rdata = st_q.out_data;
      iolcb_pkg::OFS_PIN_LEVEL: rdata = st_q.pin_level;
      iolcb_pkg::OFS_IRQ_MASK: rdata = st_q.irq_mask;
      iolcb_pkg::OFS_CHG_STATUS: rdata = st_q.chg;
      iolcb_pkg::OFS_OD_STATUS: rdata = st_q.od;
      iolcb_pkg::OFS_PU_STATUS: rdata = st_q.pu_off;
      iolcb_pkg::OFS_PSEL_STATUS: rdata = st_q.b_sel;
      iolcb_pkg::OFS_OW_STATUS: rdata = st_q.ow;
      iolcb_pkg::OFS_IRQ_EN, iolcb_pkg::OFS_IRQ_DIS, iolcb_pkg::OFS_OD_EN, iolcb_pkg::OFS_OD_DIS,
      iolcb_pkg::OFS_PU_DIS, iolcb_pkg::OFS_PU_EN, iolcb_pkg::OFS_PA_SEL, iolcb_pkg::OFS_PB_SEL,
      iolcb_pkg::OFS_OW_EN, iolcb_pkg::OFS_OW_DIS: rdata = 32'h0000_0000; // write-only, reads zero
      default: mapped = 1'b0;
    endcase
  end

  // filtered pin level: a bit moves only when the last two sync stages agree
  assign agree = ~(st_q.sync2 ^ st_q.sync3);

  // next-state logic
  always_comb begin
    st_d = st_q;
    // three-stage synchroniser; sync1 feeds only sync2
    st_d.sync1 = pad_in & LINE_MASK;
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    st_d.pin_level = (agree & st_q.sync3) | (~agree & st_q.pin_level);
    chg_set = st_d.pin_level ^ st_q.pin_level;
    // clear only what the completing read reported, so a late edge survives
    // clear on read
    chg_clr = (rd_done && req.addr == iolcb_pkg::OFS_CHG_STATUS) ? st_q.prdata : 32'h0000_0000;
    st_d.chg = (st_q.chg & ~chg_clr) | chg_set;

    if (wr_done) begin
      case (req.addr)
        iolcb_pkg::OFS_OUT_EN: st_d.out_en = req.wdata;
        iolcb_pkg::OFS_OUT_DATA: st_d.out_data = (st_q.out_data & ~st_q.ow) | (req.wdata & st_q.ow);
        iolcb_pkg::OFS_IRQ_EN: st_d.irq_mask = st_q.irq_mask | req.wdata;
        iolcb_pkg::OFS_IRQ_DIS: st_d.irq_mask = st_q.irq_mask & ~req.wdata;
        iolcb_pkg::OFS_OD_EN: st_d.od = st_q.od | req.wdata;
        iolcb_pkg::OFS_OD_DIS: st_d.od = st_q.od & ~req.wdata;
        iolcb_pkg::OFS_PU_DIS: st_d.pu_off = st_q.pu_off | req.wdata;
        iolcb_pkg::OFS_PU_EN: st_d.pu_off = st_q.pu_off & ~req.wdata;
        iolcb_pkg::OFS_PA_SEL: st_d.b_sel = st_q.b_sel & ~req.wdata;
        iolcb_pkg::OFS_PB_SEL: st_d.b_sel = st_q.b_sel | req.wdata;
        iolcb_pkg::OFS_OW_EN: st_d.ow = st_q.ow | req.wdata;
        iolcb_pkg::OFS_OW_DIS: st_d.ow = st_q.ow & ~req.wdata;
        default: st_d.out_en = st_q.out_en;
      endcase
    end

    // pad drive from the next configuration, so pins follow with one flop
    // open drain never drives high
    st_d.pad_out = ~st_d.od & st_d.out_data;
    st_d.pad_oe = st_d.out_en & ~(st_d.od & st_d.out_data);
    // pull-up pin gets its own flop so the pad sees no gate after the register
    st_d.pullup_en = ~st_d.pu_off & LINE_MASK;

    st_d.irq = |(st_d.chg & st_d.irq_mask);

    // bus answer: ready pulses in the first access cycle
    st_d.pready = setup;
    st_d.pslverr = setup & ~mapped;
    st_d.prdata = setup ? rdata : st_q.prdata;
  end

  // state register
  // defined reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.out_en <= iolcb_pkg::RST_OUT_EN;
      st_q.out_data <= iolcb_pkg::RST_OUT_DATA;
      st_q.od <= iolcb_pkg::RST_OD;
      st_q.pu_off <= iolcb_pkg::RST_PU_OFF;
      st_q.pullup_en <= LINE_MASK & ~iolcb_pkg::RST_PU_OFF;
      st_q.b_sel <= iolcb_pkg::RST_B_SEL;
      st_q.ow <= iolcb_pkg::RST_OW;
      st_q.irq_mask <= iolcb_pkg::RST_IRQ_MASK;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs, all straight from flops
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign pad_out = st_q.pad_out;
  assign pad_oe = st_q.pad_oe;
  assign pullup_en = st_q.pullup_en;
  assign periph_b_sel = st_q.b_sel;
  assign irq = st_q.irq;

  // checks on the bank's own behaviour
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_write_to(logic [11:0] ofs);
    psel && penable && pwrite && pready && paddr == ofs;
  endsequence

  sequence s_read_of(logic [11:0] ofs);
    psel && penable && !pwrite && pready && paddr == ofs;
  endsequence

  // a setup cycle is answered one cycle later, exactly once
  AST_READY_TIMING: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready did not pulse once after setup");

  // a reported change bit is gone after the read unless a new change came
  AST_CHG_CLEAR: assert property (
    s_read_of(iolcb_pkg::OFS_CHG_STATUS) ##0 (prdata[0] && st_d.pin_level[0] == st_q.pin_level[0]) |=> !st_q.chg[0])
    else $error("change bit not cleared by read");

  // a filtered level change sets its status bit on the next edge
  AST_CHG_SET: assert property ((st_d.pin_level[0] != st_q.pin_level[0]) |=> st_q.chg[0])
    else $error("level change lost");

  // a clear status bit without a level change stays clear
  AST_CHG_HOLD: assert property (!st_q.chg[0] && st_d.pin_level[0] == st_q.pin_level[0] |=> !st_q.chg[0])
    else $error("status set without change");

  // a pad steady for six samples shows in the pin level; six covers the release edge plus three stages
  AST_PIN_FOLLOW: assert property ($stable(pad_in[0]) [*6] |-> st_q.pin_level[0] == pad_in[0])
    else $error("pin level does not follow pad");

  // open-drain enable then disable round trip
  AST_OD_ENABLE: assert property (s_write_to(iolcb_pkg::OFS_OD_EN) ##0 pwdata[0] |=> st_q.od[0])
    else $error("open drain enable ignored");

  AST_OD_DISABLE: assert property (s_write_to(iolcb_pkg::OFS_OD_DIS) ##0 pwdata[0] |=> !st_q.od[0])
    else $error("open drain disable ignored");

  // open-drain line never shows a high drive
  AST_OD_LOW_ONLY: assert property (st_q.od[0] |-> !(pad_oe[0] && pad_out[0]))
    else $error("open drain line driven high");

  // push-pull enabled line drives its data
  AST_PUSH_PULL: assert property (
    !st_q.od[0] && st_q.out_en[0] |-> pad_oe[0] && pad_out[0] == st_q.out_data[0])
    else $error("push-pull line not driving data");

  // pull-up disable and enable writes reach the pin in the right sense
  AST_PU_SENSE: assert property (
    s_write_to(iolcb_pkg::OFS_PU_DIS) ##0 pwdata[0] |=> !pullup_en[0] ##1 !pullup_en[0])
    else $error("pull-up still connected after disable");

  AST_PU_ENABLE: assert property (s_write_to(iolcb_pkg::OFS_PU_EN) ##0 pwdata[0] |=> pullup_en[0])
    else $error("pull-up not connected after enable");

  // function select writes
  AST_SEL_B: assert property (s_write_to(iolcb_pkg::OFS_PB_SEL) ##0 pwdata[0] |=> periph_b_sel[0])
    else $error("select b ignored");

  AST_SEL_A: assert property (s_write_to(iolcb_pkg::OFS_PA_SEL) ##0 pwdata[0] |=> !periph_b_sel[0])
    else $error("select a ignored");

  // locked line ignores a direct data write
  AST_OW_LOCKED: assert property (
    s_write_to(iolcb_pkg::OFS_OUT_DATA) ##0 !st_q.ow[0] |=> $stable(st_q.out_data[0]))
    else $error("locked line took direct write");

  AST_OW_OPEN: assert property (
    s_write_to(iolcb_pkg::OFS_OUT_DATA) ##0 st_q.ow[0] |=> st_q.out_data[0] == $past(pwdata[0]))
    else $error("unlocked line missed direct write");

  // interrupt follows masked change status
  AST_IRQ: assert property (irq == |(st_q.chg & st_q.irq_mask))
    else $error("interrupt disagrees with masked status");

  // writes of zero to a set or clear register leave its setting as it was; set-clear pairs must not disturb neighbours
  AST_OD_EN_ZERO: assert property (
    s_write_to(iolcb_pkg::OFS_OD_EN) ##0 !pwdata[0] |=> $stable(st_q.od[0]))
    else $error("open drain enable write of zero changed the line");

  AST_OD_DIS_ZERO: assert property (
    s_write_to(iolcb_pkg::OFS_OD_DIS) ##0 !pwdata[0] |=> $stable(st_q.od[0]))
    else $error("open drain disable write of zero changed the line");

  AST_PU_DIS_ZERO: assert property (
    s_write_to(iolcb_pkg::OFS_PU_DIS) ##0 !pwdata[0] |=> $stable(pullup_en[0]))
    else $error("pull-up disable write of zero changed the line");

  AST_PU_EN_ZERO: assert property (
    s_write_to(iolcb_pkg::OFS_PU_EN) ##0 !pwdata[0] |=> $stable(pullup_en[0]))
    else $error("pull-up enable write of zero changed the line");

  AST_SEL_A_ZERO: assert property (
    s_write_to(iolcb_pkg::OFS_PA_SEL) ##0 !pwdata[0] |=> $stable(periph_b_sel[0]))
    else $error("select a write of zero changed the line");

  AST_SEL_B_ZERO: assert property (
    s_write_to(iolcb_pkg::OFS_PB_SEL) ##0 !pwdata[0] |=> $stable(periph_b_sel[0]))
    else $error("select b write of zero changed the line");

  AST_OW_EN_ZERO: assert property (
    s_write_to(iolcb_pkg::OFS_OW_EN) ##0 !pwdata[0] |=> $stable(st_q.ow[0]))
    else $error("output write enable of zero changed the line");

  AST_OW_DIS_ZERO: assert property (
    s_write_to(iolcb_pkg::OFS_OW_DIS) ##0 !pwdata[0] |=> $stable(st_q.ow[0]))
    else $error("output write disable of zero changed the line");

  // output-write lock and unlock writes
  AST_OW_ENABLE: assert property (
    s_write_to(iolcb_pkg::OFS_OW_EN) ##0 pwdata[0] |=> st_q.ow[0])
    else $error("output write enable ignored");

  AST_OW_DISABLE: assert property (
    s_write_to(iolcb_pkg::OFS_OW_DIS) ##0 pwdata[0] |=> !st_q.ow[0])
    else $error("output write disable ignored");

  // status reads agree with what the pins and state show; nothing can write between setup and access
  AST_OD_STATUS_RD: assert property (
    s_read_of(iolcb_pkg::OFS_OD_STATUS) |-> prdata[0] == st_q.od[0])
    else $error("open drain status read wrong");

  AST_PU_STATUS_RD: assert property (
    s_read_of(iolcb_pkg::OFS_PU_STATUS) |-> prdata[0] == !pullup_en[0])
    else $error("pull-up status sense wrong");

  AST_SEL_STATUS_RD: assert property (
    s_read_of(iolcb_pkg::OFS_PSEL_STATUS) |-> prdata[0] == periph_b_sel[0])
    else $error("selection status disagrees with pin");

  AST_OW_STATUS_RD: assert property (
    s_read_of(iolcb_pkg::OFS_OW_STATUS) |-> prdata[0] == st_q.ow[0])
    else $error("output write status read wrong");

  AST_DATA_RD: assert property (
    s_read_of(iolcb_pkg::OFS_OUT_DATA) |-> prdata[0] == st_q.out_data[0])
    else $error("output data readback wrong");

  // open-drain and idle pad drive
  AST_OD_SINK: assert property (
    st_q.od[0] && st_q.out_en[0] && !st_q.out_data[0] |-> pad_oe[0] && !pad_out[0])
    else $error("open drain line not pulling low");

  AST_OD_RELEASE: assert property (st_q.od[0] && st_q.out_data[0] |-> !pad_oe[0])
    else $error("open drain line drives a high");

  AST_IDLE_PAD: assert property (!st_q.out_en[0] |-> !pad_oe[0])
    else $error("disabled line still driven");

  // read data holds outside setup, since the status clear uses the held snapshot
  AST_PRDATA_HOLD: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");

  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");

endmodule // iolcb_bank

`default_nettype wire

// file: iolcb_pads_model.sv
// pad-side model: resolves each line from device drive, outside drive and pull-up
`timescale 1ns/1ps
`default_nettype none

module iolcb_pads_model (
  input wire logic pclk,
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe,
  input wire logic [31:0] pullup_en,
  input wire logic [31:0] ext_oe,
  input wire logic [31:0] ext_val,
  output logic [31:0] pad_in
);
  logic [31:0] flt_q = 32'h0;

  // floating lines wander each cycle so no stale level can pass for a real one
  always @(posedge pclk) begin
    flt_q <= ~flt_q;
  end

  // device first, then outside, then pull-up
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_oe[i]) pad_in[i] = ext_val[i];
      else if (pullup_en[i]) pad_in[i] = 1'b1;
      else pad_in[i] = flt_q[i];
    end
  end
endmodule // iolcb_pads_model

`default_nettype wire

// file: iolcb_pkg.sv
// package of constants and types for the io line control bank
package iolcb_pkg;

  // register bank width, one bit per line
  localparam int unsigned MAX_LINES = 32;

  // register byte offsets
  localparam logic [11:0] OFS_OUT_EN = 12'h010;
  localparam logic [11:0] OFS_OUT_DATA = 12'h038;
  localparam logic [11:0] OFS_PIN_LEVEL = 12'h03c;
  localparam logic [11:0] OFS_IRQ_EN = 12'h040;
  localparam logic [11:0] OFS_IRQ_DIS = 12'h044;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h048;
  localparam logic [11:0] OFS_CHG_STATUS = 12'h04c;
  localparam logic [11:0] OFS_OD_EN = 12'h050;
  localparam logic [11:0] OFS_OD_DIS = 12'h054;
  localparam logic [11:0] OFS_OD_STATUS = 12'h058;
  localparam logic [11:0] OFS_PU_DIS = 12'h060;
  localparam logic [11:0] OFS_PU_EN = 12'h064;
  localparam logic [11:0] OFS_PU_STATUS = 12'h068;
  localparam logic [11:0] OFS_PA_SEL = 12'h070;
  localparam logic [11:0] OFS_PB_SEL = 12'h074;
  localparam logic [11:0] OFS_PSEL_STATUS = 12'h078;
  localparam logic [11:0] OFS_OW_EN = 12'h0a0;
  localparam logic [11:0] OFS_OW_DIS = 12'h0a4;
  localparam logic [11:0] OFS_OW_STATUS = 12'h0a8;

  // values after reset
  localparam logic [31:0] RST_OUT_EN = 32'h0000_0000;
  localparam logic [31:0] RST_OUT_DATA = 32'h0000_0000;
  localparam logic [31:0] RST_OD = 32'h0000_0000;
  localparam logic [31:0] RST_PU_OFF = 32'h0000_0000;
  localparam logic [31:0] RST_B_SEL = 32'h0000_0000;
  localparam logic [31:0] RST_OW = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_MASK = 32'h0000_0000;

  // apb request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } iolcb_apb_req_s;

  // whole state of the bank
  typedef struct packed {
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [31:0] sync3;
    logic [31:0] pin_level;
    logic [31:0] chg;
    logic [31:0] od;
    logic [31:0] pu_off;
    logic [31:0] b_sel;
    logic [31:0] ow;
    logic [31:0] out_en;
    logic [31:0] out_data;
    logic [31:0] irq_mask;
    logic [31:0] pad_out;
    logic [31:0] pad_oe;
    logic [31:0] pullup_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } iolcb_state_s;

endpackage

// file: iolcb_tb.sv
// self-checking bench for the io line control bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((e) !== (s)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, s); end end

module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pad_in, pad_out, pad_oe, pullup_en, periph_b_sel, ext_oe, ext_val, a, b;
  logic [11:0] so [4];
  logic [11:0] co [4];
  logic [11:0] st [4];
  logic [64:0] q [$];
  logic [64:0] n;
  int bad_count = 0;
  int samples_checked = 0;

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  iolcb_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pullup_en(pullup_en), .periph_b_sel(periph_b_sel), .irq(irq));
  iolcb_pads_model pads (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe), .pullup_en(pullup_en),
    .ext_oe(ext_oe), .ext_val(ext_val), .pad_in(pad_in));

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one apb transfer; every transfer leaves its expectation {err, mask, data} in the queue
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [64:0] e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (psel && penable && pready) break;
    end
    if (i == 16) begin
      bad_count++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 65'h0);
  endtask

  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0, {1'b0, 32'hffff_ffff, e});
  endtask

  // completed transfers are matched against the oldest note; mask 0 checks the error only
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      n = q.pop_front();
      `CHK("prdata", n[31:0] & n[63:32], prdata & n[63:32])
      `CHK("pslverr", n[64], pslverr)
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, ext_oe, ext_val, presetn} = '0;
    so = '{iolcb_pkg::OFS_OD_EN, iolcb_pkg::OFS_PU_DIS, iolcb_pkg::OFS_PB_SEL, iolcb_pkg::OFS_OW_EN};
    co = '{iolcb_pkg::OFS_OD_DIS, iolcb_pkg::OFS_PU_EN, iolcb_pkg::OFS_PA_SEL, iolcb_pkg::OFS_OW_DIS};
    st = '{iolcb_pkg::OFS_OD_STATUS, iolcb_pkg::OFS_PU_STATUS, iolcb_pkg::OFS_PSEL_STATUS,
      iolcb_pkg::OFS_OW_STATUS};
    a = $urandom(32'h91569a69);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("pullup_en", 32'hffff_ffff, pullup_en)
    `CHK("periph_b_sel", 32'h0, periph_b_sel)
    repeat (8) @(posedge pclk);
    apb(1'b0, iolcb_pkg::OFS_CHG_STATUS, 32'h0, 65'h0);
    rd(iolcb_pkg::OFS_CHG_STATUS, 32'h0);
    $display("test reset done");
    // set, clear and status trios, with writes of zero in between
    for (int k = 0; k < 4; k++) begin
      rd(st[k], 32'h0);
      a = $urandom;
      b = $urandom;
      wr(so[k], a);
      wr(so[k], 32'h0);
      rd(st[k], a);
      wr(co[k], b);
      wr(co[k], 32'h0);
      rd(st[k], a & ~b);
      if (k == 1) `CHK("pullup_en", ~(a & ~b), pullup_en)
      if (k == 2) `CHK("periph_b_sel", a & ~b, periph_b_sel)
      wr(co[k], 32'hffff_ffff);
    end
    $display("test set clear done");
    a = $urandom;
    b = $urandom;
    wr(iolcb_pkg::OFS_OW_EN, a);
    wr(iolcb_pkg::OFS_OUT_DATA, b);
    rd(iolcb_pkg::OFS_OUT_DATA, a & b);
    wr(iolcb_pkg::OFS_OUT_DATA, ~b);
    rd(iolcb_pkg::OFS_OUT_DATA, a & ~b);
    $display("test write mask done");
    wr(iolcb_pkg::OFS_OW_EN, 32'hffff_ffff);
    wr(iolcb_pkg::OFS_OUT_EN, 32'hffff_ffff);
    wr(iolcb_pkg::OFS_OUT_DATA, b);
    wr(iolcb_pkg::OFS_OD_EN, a);
    @(posedge pclk);
    `CHK("pad_oe", ~a | ~b, pad_oe)
    `CHK("pad_out", b & ~a, pad_out)
    repeat (5) @(posedge pclk);
    rd(iolcb_pkg::OFS_PIN_LEVEL, b);
    wr(iolcb_pkg::OFS_OD_DIS, 32'hffff_ffff);
    wr(iolcb_pkg::OFS_OUT_EN, 32'h0);
    rd(iolcb_pkg::OFS_OUT_EN, 32'h0);
    $display("test drive done");
    repeat (6) @(posedge pclk);
    apb(1'b0, iolcb_pkg::OFS_CHG_STATUS, 32'h0, 65'h0);
    ext_oe <= 32'h8;
    repeat (6) @(posedge pclk);
    wr(iolcb_pkg::OFS_IRQ_EN, 32'h8);
    repeat (2) @(posedge pclk);
    `CHK("irq", 1'b1, irq)
    rd(iolcb_pkg::OFS_CHG_STATUS, 32'h8);
    repeat (2) @(posedge pclk);
    `CHK("irq", 1'b0, irq)
    ext_oe <= 32'h0;
    repeat (6) @(posedge pclk);
    ext_oe <= 32'h8;
    repeat (6) @(posedge pclk);
    rd(iolcb_pkg::OFS_CHG_STATUS, 32'h8);
    rd(iolcb_pkg::OFS_CHG_STATUS, 32'h0);
    rd(iolcb_pkg::OFS_IRQ_MASK, 32'h8);
    wr(iolcb_pkg::OFS_IRQ_DIS, 32'h8);
    rd(iolcb_pkg::OFS_IRQ_MASK, 32'h0);
    $display("test change done");
    apb(1'b0, 12'h0fc, 32'h0, {1'b1, 32'hffff_ffff, 32'h0});
    apb(1'b1, 12'h0fc, 32'hffff_ffff, {1'b1, 64'h0});
    wr(iolcb_pkg::OFS_OD_STATUS, 32'hffff_ffff);
    rd(iolcb_pkg::OFS_OD_STATUS, 32'h0);
    $display("test refusal done");
    wr(iolcb_pkg::OFS_OD_EN, 32'hffff_ffff);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(iolcb_pkg::OFS_OD_STATUS, 32'h0);
    $display("test second reset done");
    repeat (2) @(posedge pclk);
    wrap_up();
  end
endmodule // tb

`default_nettype wire
